// File: src/sleep_ctrl_pkg.sv
// Constants and types for the sleep-mode clock gating controller
package sleep_ctrl_pkg;

  localparam logic [2:0] MODE_IDLE      = 3'h0;
  localparam logic [2:0] MODE_ADC_NR    = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
  localparam logic [2:0] MODE_STANDBY   = 3'h6;
  localparam logic [2:0] MODE_EXT_STBY  = 3'h7;

  localparam int unsigned STANDBY_WAKE_CYCLES = 6;
  localparam int unsigned CPU_HOLD_CYCLES     = 4;
  localparam int unsigned CLK_PERIOD_NS       = 20;
  localparam int unsigned LEVEL_HOLD_NS       = 1000;
  localparam int unsigned LEVEL_HOLD_CYCLES   =
    (LEVEL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] DEFAULT_STARTUP_CYCLES = 16'h0400;

  typedef enum logic [3:0]
  {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_HOLD  = 4'h8
  } sleep_state_t;

endpackage : sleep_ctrl_pkg

// File: src/wake_level_filter.sv
// Holds off a level wake request until the level has stood long enough
`timescale 1ns/1ns
module wake_level_filter #(
  parameter int unsigned HOLD = 50
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic level_in,
  output logic      level_ok
);
  import sleep_ctrl_pkg::*;

  logic [15:0] count_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset || !level_in)
    begin
      count_reg <= 16'h0000;
      level_ok  <= 1'b0;
    end
    else if (count_reg >= 16'(HOLD - 1))
      level_ok <= 1'b1;
    else
      count_reg <= count_reg + 16'h0001;
  end

endmodule : wake_level_filter

// File: src/sleep_mode_clock_gating.sv
// Sleep-mode controller: mode decode, clock gating, wake filtering and start-up delay
`timescale 1ns/1ns
module sleep_mode_clock_gating #(
  parameter int unsigned UPPER_LINES = 4,
  parameter int unsigned LOWER_LINES = 4
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic [2:0]             sleep_mode_select,
  input  wire logic                   sleep_arm,
  input  wire logic                   sleep_exec,
  input  wire logic                   crystal_selected,
  input  wire logic [15:0]            startup_cycles,
  input  wire logic                   timer0_async_select,
  input  wire logic                   timer0_ovf_irq,
  input  wire logic                   timer0_cmp_irq,
  input  wire logic                   timer0_ovf_en,
  input  wire logic                   timer0_cmp_en,
  input  wire logic                   global_irq_en,
  input  wire logic                   any_enabled_irq,
  input  wire logic                   conv_done_irq,
  input  wire logic                   twi_match_irq,
  input  wire logic                   store_ready_irq,
  input  wire logic [UPPER_LINES-1:0] ext_irq_upper_lines,
  input  wire logic [LOWER_LINES-1:0] ext_irq_lower_lines,
  input  wire logic                   reset_wake,
  input  wire logic                   converter_enable,
  input  wire logic                   comparator_power_off,
  input  wire logic                   comparator_uses_ref,
  input  wire logic                   brownout_enable_fuse,
  input  wire logic                   watchdog_enable,
  output logic                        cpu_clock_domain,
  output logic                        flash_clock_domain,
  output logic                        io_clock_domain,
  output logic                        converter_clock_domain,
  output logic                        async_clock_domain,
  output logic                        main_osc_enable,
  output logic                        conv_start,
  output logic                        conv_extended,
  output logic                        comparator_enable,
  output logic                        brownout_enable,
  output logic                        watchdog_run,
  output logic                        vref_enable,
  output logic                        input_buffer_enable,
  output logic                        wake_pin_buffer_enable,
  output logic                        sleeping,
  output logic                        irq_dispatch
);
  import sleep_ctrl_pkg::*;

  sleep_state_t state_reg;
  sleep_state_t state_next;
  logic [2:0]   mode_reg;
  logic [15:0]  count_reg;
  logic         irq_wake_reg;
  logic         conv_en_d_reg;
  logic         conv_off_seen_reg;
  logic         upper_ok;
  logic         wake_req;
  logic [2:0]   eff_mode;

  // Reserved codes and crystal-less standby fall back to Idle, the safest choice
  function automatic logic [2:0] resolve_mode(input logic [2:0] sel, input logic xtal);
    case (sel)
      MODE_IDLE, MODE_ADC_NR, MODE_PWR_DOWN, MODE_PWR_SAVE: resolve_mode = sel;
      MODE_STANDBY, MODE_EXT_STBY: resolve_mode = xtal ? sel : MODE_IDLE;
      default: resolve_mode = MODE_IDLE;
    endcase
  endfunction : resolve_mode

  function automatic logic osc_stops(input logic [2:0] m);
    osc_stops = (m == MODE_PWR_DOWN) || (m == MODE_PWR_SAVE);
  endfunction : osc_stops

  assign eff_mode = resolve_mode(sleep_mode_select, crystal_selected);

  wake_level_filter #(
    .HOLD (LEVEL_HOLD_CYCLES)
  ) u_upper_filter (
    .core_clk (core_clk),
    .reset    (reset),
    .level_in (|ext_irq_upper_lines),
    .level_ok (upper_ok)
  );

  logic t0_wake;
  assign t0_wake = timer0_async_select && global_irq_en &&
                   ((timer0_ovf_irq && timer0_ovf_en) ||
                    (timer0_cmp_irq && timer0_cmp_en));

  always_comb
  begin
    case (mode_reg)
      MODE_IDLE:     wake_req = any_enabled_irq || reset_wake;
      MODE_ADC_NR:   wake_req = conv_done_irq || reset_wake || twi_match_irq ||
                                (timer0_ovf_irq || timer0_cmp_irq) || store_ready_irq ||
                                upper_ok || (|ext_irq_lower_lines);
      MODE_PWR_DOWN,
      MODE_STANDBY:  wake_req = reset_wake || twi_match_irq || upper_ok ||
                                (|ext_irq_lower_lines);
      MODE_PWR_SAVE,
      MODE_EXT_STBY: wake_req = reset_wake || twi_match_irq || upper_ok ||
                                (|ext_irq_lower_lines) || t0_wake;
      default:       wake_req = reset_wake;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:   if (sleep_exec && sleep_arm) state_next = ST_SLEEP;
      ST_SLEEP: if (wake_req) state_next = ST_START;
      ST_START: if (count_reg == 16'h0000) state_next = reset_wake ? ST_RUN : ST_HOLD;
      ST_HOLD:  if (count_reg == 16'h0000) state_next = ST_RUN;
      default:  state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      mode_reg <= MODE_IDLE;
    else if (state_reg == ST_RUN && sleep_exec && sleep_arm)
      mode_reg <= eff_mode;
  end

  // Start-up delay, then the interrupt hold; the counter is shared between the two
  always_ff @(posedge core_clk)
  begin
    if (reset)
      count_reg <= 16'h0000;
    else if (state_reg == ST_SLEEP && wake_req)
    begin
      if (osc_stops(mode_reg))
        count_reg <= (startup_cycles == 16'h0000) ? 16'h0000
                     : startup_cycles - 16'h0001;
      else if (mode_reg == MODE_STANDBY || mode_reg == MODE_EXT_STBY)
        count_reg <= 16'(STANDBY_WAKE_CYCLES - 1);
      else
        count_reg <= 16'h0000;
    end
    else if (state_reg == ST_START && count_reg == 16'h0000)
      count_reg <= 16'(CPU_HOLD_CYCLES - 1);
    else if (count_reg != 16'h0000)
      count_reg <= count_reg - 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_wake_reg <= 1'b0;
    else if (state_reg == ST_SLEEP && wake_req)
      irq_wake_reg <= !reset_wake;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_dispatch <= 1'b0;
    else
      irq_dispatch <= (state_reg == ST_HOLD) && (count_reg == 16'h0000) && irq_wake_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      conv_start <= 1'b0;
    else
      conv_start <= state_reg == ST_RUN && sleep_exec && sleep_arm && converter_enable &&
                    (eff_mode == MODE_IDLE || eff_mode == MODE_ADC_NR);
  end

  // Off-then-on of the converter marks the next conversion as extended
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      conv_en_d_reg     <= 1'b0;
      conv_off_seen_reg <= 1'b0;
      conv_extended     <= 1'b1;
    end
    else
    begin
      conv_en_d_reg <= converter_enable;
      if (conv_en_d_reg && !converter_enable)
        conv_off_seen_reg <= 1'b1;
      if (!conv_en_d_reg && converter_enable && conv_off_seen_reg)
        conv_extended <= 1'b1;
      else if (conv_start)
        conv_extended <= 1'b0;
    end
  end

  logic asleep;
  logic deep;
  assign asleep = (state_reg == ST_SLEEP) || (state_reg == ST_START);
  assign deep   = asleep && mode_reg != MODE_IDLE && mode_reg != MODE_ADC_NR;

  always_comb
  begin
    cpu_clock_domain       = !asleep;
    flash_clock_domain     = !asleep;
    io_clock_domain        = !asleep || mode_reg == MODE_IDLE;
    converter_clock_domain = !asleep || mode_reg == MODE_IDLE || mode_reg == MODE_ADC_NR;
    async_clock_domain     = !asleep || mode_reg == MODE_IDLE || mode_reg == MODE_ADC_NR ||
                             ((mode_reg == MODE_PWR_SAVE || mode_reg == MODE_EXT_STBY) &&
                              timer0_async_select);
    main_osc_enable        = !(asleep && osc_stops(mode_reg) && state_reg == ST_SLEEP);
    comparator_enable      = !comparator_power_off && !deep;
    brownout_enable        = brownout_enable_fuse;
    watchdog_run           = watchdog_enable;
    vref_enable            = brownout_enable_fuse || converter_enable ||
                             (!comparator_power_off && comparator_uses_ref);
    input_buffer_enable    = io_clock_domain || converter_clock_domain;
    wake_pin_buffer_enable = 1'b1;
    sleeping               = asleep;
  end

endmodule : sleep_mode_clock_gating

// File: sim/sleep_ctrl_properties.sv
// Port-level checks of the sleep controller
`timescale 1ns/1ns
module sleep_ctrl_properties (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [2:0] sleep_mode_select,
  input wire logic       sleep_arm,
  input wire logic       sleep_exec,
  input wire logic       crystal_selected,
  input wire logic       converter_enable,
  input wire logic       comparator_uses_ref,
  input wire logic       brownout_enable_fuse,
  input wire logic       watchdog_enable,
  input wire logic       reset_wake,
  input wire logic       cpu_clock_domain,
  input wire logic       flash_clock_domain,
  input wire logic       io_clock_domain,
  input wire logic       converter_clock_domain,
  input wire logic       main_osc_enable,
  input wire logic       conv_start,
  input wire logic       comparator_enable,
  input wire logic       brownout_enable,
  input wire logic       watchdog_run,
  input wire logic       vref_enable,
  input wire logic       input_buffer_enable,
  input wire logic       wake_pin_buffer_enable,
  input wire logic       sleeping,
  input wire logic       irq_dispatch
);
  import sleep_ctrl_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence take_req(logic [2:0] m);
    !sleeping && sleep_arm && sleep_exec && sleep_mode_select == m;
  endsequence
  sequence hold_then_dispatch;
    !irq_dispatch [*3] ##[1:2] irq_dispatch;
  endsequence
  chk_idle_gates: assert property (take_req(MODE_IDLE) |=> sleeping && !cpu_clock_domain
    && !flash_clock_domain && io_clock_domain) else $error("idle gating wrong");
  chk_idle_conv: assert property (take_req(MODE_IDLE) ##0 converter_enable |=> conv_start)
    else $error("no conversion start on idle entry");
  chk_nr_gates: assert property (take_req(MODE_ADC_NR) |=> !io_clock_domain
    && converter_clock_domain) else $error("noise reduction gating wrong");
  chk_pdown_osc: assert property (take_req(MODE_PWR_DOWN) |=> !main_osc_enable
    && !converter_clock_domain) else $error("power-down left clocks on");
  chk_stby_osc: assert property (take_req(MODE_STANDBY) ##0 crystal_selected |=>
    main_osc_enable && !io_clock_domain) else $error("standby oscillator wrong");
  chk_reserved_idle: assert property (take_req(3'h4) |=> sleeping && io_clock_domain)
    else $error("reserved mode not handled as idle");
  chk_arm_needed: assert property (!sleeping && sleep_exec && !sleep_arm |=> !sleeping)
    else $error("slept without arm");
  chk_hold_dispatch: assert property ($fell(sleeping) && !reset_wake |-> hold_then_dispatch)
    else $error("dispatch not after four-cycle hold");
  chk_bod_kept: assert property (brownout_enable == brownout_enable_fuse)
    else $error("brown-out enable lost");
  chk_wdog_kept: assert property (watchdog_run == watchdog_enable)
    else $error("watchdog enable lost");
  chk_buffers_off: assert property (input_buffer_enable == (io_clock_domain
    || converter_clock_domain) && wake_pin_buffer_enable) else $error("buffer enable wrong");
  chk_vref_need: assert property ((brownout_enable_fuse || converter_enable) |-> vref_enable)
    else $error("reference off while needed");
  chk_cmp_deep: assert property (sleeping && !io_clock_domain && !converter_clock_domain
    && !comparator_uses_ref |-> !comparator_enable) else $error("comparator on in deep sleep");
endmodule : sleep_ctrl_properties

bind sleep_mode_clock_gating sleep_ctrl_properties u_sleep_ctrl_properties (.*);

// File: sim/wake_source_model.sv
// Wake source: holds an upper external line at its level for a set time
`timescale 1ns/1ns
module wake_source_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       fire,
  input  wire logic [7:0] hold_len,
  output logic      [3:0] upper_line
);
  logic [7:0] count_reg;
  always_ff @(posedge core_clk)
  begin
    if (reset)
      count_reg <= 8'h00;
    else if (fire)
      count_reg <= hold_len;
    else if (count_reg != 8'h00)
      count_reg <= count_reg - 8'h01;
  end
  // Released line falls to its idle low level
  assign upper_line = {3'h0, count_reg != 8'h00};
endmodule : wake_source_model

// File: sim/test_sleep_mode_clock_gating.sv
// Self-checking bench for the sleep-mode clock gating controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_sleep_mode_clock_gating;
  import sleep_ctrl_pkg::*;
  logic core_clk, reset, arm, ex, xtal, asy, ovf, ovf_en, gie, anyi, cdone, twi;
  logic conv_en, cpoff, cref, bod, wdt, fire, cpu, io, cvk, ack, osc, cst, vref, ibuf, wpin;
  logic sleeping, disp, bodo, wdo, cmpo;
  logic [2:0] mode;
  logic [3:0] upper, lower;
  logic [7:0] hlen;
  int num_errors, checked, disp_seen, start_seen;
  sleep_mode_clock_gating u_sleep_mode_clock_gating (.core_clk(core_clk), .reset(reset),
    .sleep_mode_select(mode), .sleep_arm(arm), .sleep_exec(ex), .crystal_selected(xtal),
    .startup_cycles(16'h0010), .timer0_async_select(asy), .timer0_ovf_irq(ovf),
    .timer0_cmp_irq(1'b0), .timer0_ovf_en(ovf_en), .timer0_cmp_en(1'b0), .global_irq_en(gie),
    .any_enabled_irq(anyi), .conv_done_irq(cdone), .twi_match_irq(twi), .store_ready_irq(1'b0),
    .ext_irq_upper_lines(upper), .ext_irq_lower_lines(lower), .reset_wake(1'b0),
    .converter_enable(conv_en), .comparator_power_off(cpoff), .comparator_uses_ref(cref),
    .brownout_enable_fuse(bod), .watchdog_enable(wdt), .cpu_clock_domain(cpu),
    .flash_clock_domain(), .io_clock_domain(io), .converter_clock_domain(cvk),
    .async_clock_domain(ack), .main_osc_enable(osc), .conv_start(cst), .conv_extended(),
    .comparator_enable(cmpo), .brownout_enable(bodo), .watchdog_run(wdo), .vref_enable(vref),
    .input_buffer_enable(ibuf), .wake_pin_buffer_enable(wpin), .sleeping(sleeping),
    .irq_dispatch(disp));
  wake_source_model u_wake_source_model (.core_clk(core_clk), .reset(reset), .fire(fire),
    .hold_len(hlen), .upper_line(upper));
  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    disp_seen += (disp === 1'b1);
    start_seen += (cst === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic go(input logic [2:0] m);
    tick(1);
    {mode, arm, ex} = {m, 2'b11};
    tick(1);
    {arm, ex} = 2'b00;
    tick(1);
  endtask : go
  task automatic woke(input int lo, input int hi);
    int n;
    int nd;
    n = 0;
    nd = disp_seen;
    while (sleeping === 1'b1 && n < 500)
    begin
      tick(1);
      n++;
    end
    {anyi, cdone, twi, lower, ovf} = 8'h00;
    tick(8);
    `CHK("wake_time", 1'b1, n >= lo && n <= hi)
    `CHK("dispatch", nd + 1, disp_seen)
  endtask : woke
  task automatic complete_run;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    {reset, arm, ex, xtal, asy, ovf, ovf_en, gie, anyi, cdone, twi, fire} = 12'h800;
    {conv_en, cpoff, cref, bod, wdt, mode, lower, hlen} = 0;
    {num_errors, checked, disp_seen, start_seen} = 0;
    tick(5);
    reset = 0;
    ex = 1;
    tick(2);
    ex = 0;
    `CHK("no_arm", 1'b0, sleeping)
    conv_en = 1;
    go(MODE_IDLE);
    `CHK("idle_cpu", 1'b0, cpu)
    `CHK("conv_start", 1, start_seen)
    anyi = 1;
    woke(1, 4);
    go(MODE_ADC_NR);
    `CHK("nr_io", 2'b01, {io, cvk})
    anyi = 1;
    tick(20);
    `CHK("nr_asleep", 1'b1, sleeping)
    cdone = 1;
    woke(1, 4);
    {conv_en, bod, wdt} = 3'b011;
    go(MODE_PWR_DOWN);
    `CHK("pd_outs", 6'b000111, {osc, ibuf, cmpo, wpin, bodo, wdo})
    {anyi, cdone} = 2'b11;
    tick(20);
    `CHK("pd_asleep", 1'b1, sleeping)
    lower = 4'h8;
    woke(16, 19);
    go(MODE_PWR_DOWN);
    {hlen, fire} = {8'h0a, 1'b1};
    tick(1);
    fire = 0;
    tick(30);
    `CHK("short_level", 1'b1, sleeping)
    {hlen, fire} = {8'h46, 1'b1};
    tick(1);
    fire = 0;
    woke(55, 72);
    {asy, ovf, ovf_en} = 3'b111;
    go(MODE_PWR_SAVE);
    `CHK("ps_clk", 2'b10, {ack, osc})
    tick(20);
    `CHK("ps_no_gie", 1'b1, sleeping)
    gie = 1;
    woke(16, 19);
    xtal = 1;
    for (int m = 6; m < 8; m++)
    begin
      go(m[2:0]);
      `CHK("stby_osc", 2'b10, {osc, io})
      twi = 1;
      woke(6, 8);
    end
    for (int m = 4; m < 7; m++)
    begin
      xtal = (m == 6) ? 1'b0 : 1'b1;
      go(m[2:0]);
      `CHK("fallback", 2'b11, {io, cvk})
      anyi = 1;
      woke(1, 4);
    end
    {bod, conv_en, cref, cpoff} = 4'b1001;
    tick(1);
    `CHK("vref_on", 1'b1, vref)
    bod = 0;
    tick(1);
    `CHK("vref_off", 1'b0, vref)
    complete_run();
  end
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : test_sleep_mode_clock_gating
